// [core/cirq_pkg.sv]
// constants and carrier types for the can interrupt and retransmit block
package cirq_pkg;

  // ************************************************************
  // register map (byte addresses on the apb bus)
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] MASK_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] FLAG_OFS = 12'h00C;

  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int CTRL_LINE_EN_BIT = 1;
  localparam int CTRL_STCHG_EN_BIT = 2;
  localparam int CTRL_ERR_EN_BIT = 3;
  localparam int CTRL_RSVD_BIT = 4;
  localparam int CTRL_RETX_DIS_BIT = 5;
  localparam logic CTRL_LINE_EN_RST = 1'h0;
  localparam logic CTRL_STCHG_EN_RST = 1'h0;
  localparam logic CTRL_ERR_EN_RST = 1'h0;
  localparam logic CTRL_RETX_DIS_RST = 1'h0;

  // ************************************************************
  // interrupt status and mask fields (same layout)
  // ************************************************************
  localparam int EV_N = 4;
  localparam int EV_TXOK_BIT = 0;
  localparam int EV_BERR_BIT = 1;
  localparam int EV_BUSOFF_BIT = 2;
  localparam int EV_WARN_BIT = 3;
  localparam logic [EV_N-1:0] STAT_RST = 4'h0;
  localparam logic [EV_N-1:0] MASK_RST = 4'hF;

  // ************************************************************
  // flag readback fields
  // ************************************************************
  localparam int FLAG_BUSOFF_BIT = 0;
  localparam int FLAG_WARN_BIT = 1;
  localparam int FLAG_IRQ_BIT = 2;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } cirq_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cirq_apb_rsp_t;

  typedef struct packed {
    logic tx_done;
    logic bus_err;
    logic bus_off_flag;
    logic error_warning_flag;
  } cirq_can_ev_t;

endpackage : cirq_pkg

// [core/cirq_sticky.sv]
// one sticky event bit, set by hardware, cleared by software
`timescale 1ns/100ps
module cirq_sticky
  import cirq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sys_ce,
  input wire logic set,
  input wire logic clr,
  output logic flag
);

  // set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flag <= 1'b0;
    end else if (sys_ce) begin
      flag <= set | (flag & ~clr);
    end
  end

  set_wins_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sys_ce && set |=> flag)
    else $error("sticky bit lost an event");

endmodule : cirq_sticky

// [core/cirq_ctrl.sv]
// can interrupt enables, event status and retransmit control
// Operation
// - enabled line goes low while interrupts pending
// - line enable cleared holds line high
// - status enable: transfer done or bus error interrupts
// - status enable cleared: no status change interrupt
// - error enable: bus-off or warning change interrupts
// - error enable cleared: no error interrupt
// - error enable is bit 3, resets 0
// - retransmit disable is bit 5, resets 0
`timescale 1ns/100ps
module cirq_ctrl
  import cirq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sys_ce,
  input wire cirq_apb_req_t apb_req,
  output cirq_apb_rsp_t apb_rsp,
  input wire cirq_can_ev_t can_ev,
  output logic can_irq_n,
  output logic irq,
  output logic retransmit_disable
);

  // ************************************************************
  // state
  // ************************************************************
  logic irq_line_enable_r;
  logic status_change_irq_enable_r;
  logic error_irq_enable_r;
  logic retransmit_disable_r;
  logic [EV_N-1:0] mask_r;
  logic [EV_N-1:0] status;
  logic busoff_prev_r;
  logic warn_prev_r;
  logic can_irq_n_r;
  logic irq_r;
  cirq_apb_rsp_t rsp_r;
  cirq_apb_rsp_t rsp_nxt;

  // ************************************************************
  // apb decode
  // ************************************************************
  logic acc_phase;
  logic done;
  logic wr;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_mask;
  logic sel_flag;
  logic mapped;

  // access phase waits one cycle, transfer ends when pready is seen
  assign acc_phase = apb_req.psel & apb_req.penable;
  assign done = acc_phase & rsp_r.pready;
  assign wr = done & apb_req.pwrite;
  assign sel_ctrl = apb_req.paddr == CTRL_OFS;
  assign sel_stat = apb_req.paddr == STAT_OFS;
  assign sel_mask = apb_req.paddr == MASK_OFS;
  assign sel_flag = apb_req.paddr == FLAG_OFS;
  assign mapped = sel_ctrl | sel_stat | sel_mask | sel_flag;

  // ************************************************************
  // control register
  // ************************************************************
  // reserved bit 4 has no storage at all, so it can never read back
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_line_enable_r <= CTRL_LINE_EN_RST;
      status_change_irq_enable_r <= CTRL_STCHG_EN_RST;
      error_irq_enable_r <= CTRL_ERR_EN_RST;
      retransmit_disable_r <= CTRL_RETX_DIS_RST;
    end else if (sys_ce && wr && sel_ctrl) begin
      irq_line_enable_r <= apb_req.pwdata[CTRL_LINE_EN_BIT];
      status_change_irq_enable_r <= apb_req.pwdata[CTRL_STCHG_EN_BIT];
      error_irq_enable_r <= apb_req.pwdata[CTRL_ERR_EN_BIT];
      retransmit_disable_r <= apb_req.pwdata[CTRL_RETX_DIS_BIT];
    end
  end

  // mask register, all sources unmasked after reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mask_r <= MASK_RST;
    end else if (sys_ce && wr && sel_mask) begin
      mask_r <= apb_req.pwdata[EV_N-1:0];
    end
  end

  // ************************************************************
  // event capture
  // ************************************************************
  logic busoff_chg;
  logic warn_chg;
  logic [EV_N-1:0] ev_set;
  logic [EV_N-1:0] ev_clr;

  // previous flag values; a flag high at reset counts as a change
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busoff_prev_r <= 1'b0;
      warn_prev_r <= 1'b0;
    end else if (sys_ce) begin
      busoff_prev_r <= can_ev.bus_off_flag;
      warn_prev_r <= can_ev.error_warning_flag;
    end
  end

  assign busoff_chg = can_ev.bus_off_flag ^ busoff_prev_r;
  assign warn_chg = can_ev.error_warning_flag ^ warn_prev_r;

  // enables gate the setting of sticky bits, not their readout
  always_comb begin
    ev_set = '0;
    ev_set[EV_TXOK_BIT] = status_change_irq_enable_r
      & can_ev.tx_done;
    ev_set[EV_BERR_BIT] = status_change_irq_enable_r
      & can_ev.bus_err;
    ev_set[EV_BUSOFF_BIT] = error_irq_enable_r & busoff_chg;
    ev_set[EV_WARN_BIT] = error_irq_enable_r & warn_chg;
  end

  // write one to clear
  assign ev_clr = (wr && sel_stat) ? apb_req.pwdata[EV_N-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < EV_N; gi++) begin : g_stat
      cirq_sticky u_sticky (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .sys_ce(sys_ce),
        .set(ev_set[gi]),
        .clr(ev_clr[gi]),
        .flag(status[gi])
      );
    end
  endgenerate

  // ************************************************************
  // interrupt outputs
  // ************************************************************
  logic pending;

  assign pending = |(status & mask_r);

  // line stays low until every unmasked pending bit is cleared or the line enable is cleared
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      can_irq_n_r <= 1'b1;
      irq_r <= 1'b0;
    end else if (sys_ce) begin
      can_irq_n_r <= ~(irq_line_enable_r & pending);
      irq_r <= pending;
    end
  end

  // ************************************************************
  // apb response
  // ************************************************************
  always_comb begin
    rsp_nxt = '0;
    rsp_nxt.pready = acc_phase & ~rsp_r.pready;
    if (acc_phase && !rsp_r.pready) begin
      rsp_nxt.pslverr = ~mapped;
      if (!apb_req.pwrite) begin
        if (sel_ctrl) begin
          rsp_nxt.prdata[CTRL_LINE_EN_BIT] = irq_line_enable_r;
          rsp_nxt.prdata[CTRL_STCHG_EN_BIT] = status_change_irq_enable_r;
          rsp_nxt.prdata[CTRL_ERR_EN_BIT] = error_irq_enable_r;
          rsp_nxt.prdata[CTRL_RSVD_BIT] = 1'b0;
          rsp_nxt.prdata[CTRL_RETX_DIS_BIT] = retransmit_disable_r;
        end else if (sel_stat) begin
          rsp_nxt.prdata[EV_N-1:0] = status;
        end else if (sel_mask) begin
          rsp_nxt.prdata[EV_N-1:0] = mask_r;
        end else if (sel_flag) begin
          rsp_nxt.prdata[FLAG_BUSOFF_BIT] = can_ev.bus_off_flag;
          rsp_nxt.prdata[FLAG_WARN_BIT] = can_ev.error_warning_flag;
          rsp_nxt.prdata[FLAG_IRQ_BIT] = ~can_irq_n_r;
        end
      end
    end
  end

  // response frozen with the rest when the clock enable is low
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rsp_r <= '0;
    end else if (sys_ce) begin
      rsp_r <= rsp_nxt;
    end
  end

  assign apb_rsp = rsp_r;
  assign can_irq_n = can_irq_n_r;
  assign irq = irq_r;
  assign retransmit_disable = retransmit_disable_r;

  // ************************************************************
  // checks
  // ************************************************************
  line_low_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce && irq_line_enable_r && pending |=> !can_irq_n)
    else $error("interrupt line not low while pending");

  line_held_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !can_irq_n && irq_line_enable_r && pending && !(wr && sel_ctrl)
    |=> !can_irq_n)
    else $error("interrupt line released while pending");

  line_high_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce && !irq_line_enable_r |=> can_irq_n)
    else $error("interrupt line low while disabled");

  sc_set_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce && status_change_irq_enable_r && (can_ev.tx_done || can_ev.bus_err)
    |=> status[EV_TXOK_BIT] || status[EV_BERR_BIT])
    else $error("status change event not recorded");

  txok_set_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce && status_change_irq_enable_r && can_ev.tx_done
    |=> status[EV_TXOK_BIT])
    else $error("completed transfer not recorded");

  berr_set_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce && status_change_irq_enable_r && can_ev.bus_err
    |=> status[EV_BERR_BIT])
    else $error("bus error not recorded");

  sc_quiet_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !status_change_irq_enable_r && !status[EV_TXOK_BIT]
    |=> !status[EV_TXOK_BIT])
    else $error("status change raised while disabled");

  berr_quiet_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !status_change_irq_enable_r && !status[EV_BERR_BIT]
    |=> !status[EV_BERR_BIT])
    else $error("bus error raised while disabled");

  err_set_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce && error_irq_enable_r && can_ev.bus_off_flag != busoff_prev_r
    |=> status[EV_BUSOFF_BIT])
    else $error("bus-off change not recorded");

  warn_set_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce && error_irq_enable_r && can_ev.error_warning_flag != warn_prev_r
    |=> status[EV_WARN_BIT])
    else $error("warning change not recorded");

  err_quiet_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !error_irq_enable_r && !status[EV_WARN_BIT]
    |=> !status[EV_WARN_BIT])
    else $error("error interrupt raised while disabled");

  busoff_quiet_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !error_irq_enable_r && !status[EV_BUSOFF_BIT]
    |=> !status[EV_BUSOFF_BIT])
    else $error("bus-off interrupt raised while disabled");

  err_en_reset_a: assert property (@(posedge sys_clk)
    $past(sys_rst) |-> !error_irq_enable_r && !retransmit_disable)
    else $error("control bits not zero after reset");

  retx_write_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce && wr && sel_ctrl
    |=> retransmit_disable == $past(apb_req.pwdata[CTRL_RETX_DIS_BIT]))
    else $error("retransmit disable not written");

  rsvd_zero_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce && acc_phase && !rsp_r.pready && !apb_req.pwrite && sel_ctrl
    |=> apb_rsp.pready && !apb_rsp.prdata[CTRL_RSVD_BIT])
    else $error("reserved control bit reads nonzero");

  // the level output is not gated by the line enable
  irq_level_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce |=> irq == $past(pending))
    else $error("interrupt level does not follow pending status");

  slverr_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce && acc_phase && !rsp_r.pready && !mapped
    |=> apb_rsp.pready && apb_rsp.pslverr)
    else $error("unmapped access not flagged");

  ready_pulse_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sys_ce && apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held longer than one cycle");

  // a stalled block must not drift, or software sees stale answers
  ce_freeze_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !sys_ce |=> $stable(status) && $stable(mask_r) && $stable(rsp_r)
      && $stable(can_irq_n_r) && $stable(irq_line_enable_r))
    else $error("state moved while clock enable low");

endmodule : cirq_ctrl

// [testbench/cirq_can_model.sv]
// behavioural can protocol engine feeding events and status flags
`timescale 1ns/100ps
module cirq_can_model
  import cirq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic tx_req,
  input wire logic err_req,
  input wire logic busoff_lvl,
  input wire logic warn_lvl,
  input wire logic retransmit_disable,
  output cirq_can_ev_t can_ev
);
  logic retry_r;
  // ************************************************************
  // engine
  // ************************************************************
  // a disturbed frame is resent once unless retransmit_disable is set; the resend always succeeds
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      can_ev <= '0;
      retry_r <= 1'h0;
    end else begin
      can_ev.tx_done <= tx_req | retry_r;
      can_ev.bus_err <= err_req;
      retry_r <= err_req & ~retransmit_disable;
      can_ev.bus_off_flag <= busoff_lvl;
      can_ev.error_warning_flag <= warn_lvl;
    end
  end
endmodule : cirq_can_model

// [testbench/cirq_ctrl_tb.sv]
// self-checking bench for the can interrupt and retransmit block
`timescale 1ns/100ps
module cirq_ctrl_tb
  import cirq_pkg::*;
;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [3:0] ev; // tx, err, bus-off level, warning level
    logic [7:0] rb;
    logic [3:0] st;
  } cirq_row_t;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic sys_ce = 1'h1;
  logic tx_req = 1'h0, err_req = 1'h0, busoff_lvl = 1'h0, warn_lvl = 1'h0;
  logic can_irq_n, irq, retransmit_disable;
  logic [31:0] rd;
  logic er;
  int miscompares = 0, n_checks = 0;
  cirq_apb_req_t req = '0;
  cirq_apb_rsp_t rsp;
  cirq_can_ev_t can_ev;
  cirq_row_t rows [8] = '{
    '{32'h00, 4'hC, 8'h00, 4'h0}, '{32'h04, 4'h8, 8'h04, 4'h1},
    '{32'h04, 4'h4, 8'h04, 4'h3}, '{32'h24, 4'h4, 8'h24, 4'h2},
    '{32'h00, 4'h2, 8'h00, 4'h0}, '{32'h08, 4'h0, 8'h08, 4'h4},
    '{32'h08, 4'h1, 8'h08, 4'h8}, '{32'hFFFFFFEF, 4'hB, 8'h2E, 4'h5}};

  always #10 sys_clk = ~sys_clk;

  // clock enable driven by the bench so the freeze can be exercised
  cirq_ctrl dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .sys_ce(sys_ce),
    .apb_req(req), .apb_rsp(rsp), .can_ev(can_ev), .can_irq_n(can_irq_n),
    .irq(irq), .retransmit_disable(retransmit_disable));
  cirq_can_model can_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .tx_req(tx_req), .err_req(err_req), .busoff_lvl(busoff_lvl),
    .warn_lvl(warn_lvl), .retransmit_disable(retransmit_disable),
    .can_ev(can_ev));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h want %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{1'h1, 1'h0, w, a, d};
    @(posedge sys_clk);
    req.penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.pready !== 1'h1 && n < 20);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    if (n >= 20) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    cyc(6);
    sys_rst <= 1'h0;
    apb(0, CTRL_OFS, 0); chk(rd, 32'h0);
    apb(0, MASK_OFS, 0); chk(rd, 32'hF);
    chk(can_irq_n, 1'h1);
    // each row: set enables, clear status, then raise events
    foreach (rows[i]) begin
      apb(1, CTRL_OFS, rows[i].ctrl);
      apb(1, STAT_OFS, 32'hF);
      @(posedge sys_clk);
      {tx_req, err_req, busoff_lvl, warn_lvl} <= rows[i].ev;
      @(posedge sys_clk);
      {tx_req, err_req} <= 2'h0;
      cyc(4);
      apb(0, CTRL_OFS, 0); chk(rd, rows[i].rb);
      apb(0, STAT_OFS, 0); chk(rd, rows[i].st);
      chk(retransmit_disable, rows[i].rb[5]);
    end
    // pending status 5 with line enabled
    cyc(2); chk({can_irq_n, irq}, 2'h1);
    apb(1, CTRL_OFS, 32'h2C); cyc(2); chk({can_irq_n, irq}, 2'h3);
    apb(1, CTRL_OFS, 32'h2E); apb(1, MASK_OFS, 32'h0);
    cyc(2); chk({can_irq_n, irq}, 2'h2);
    apb(1, MASK_OFS, 32'hF); apb(1, STAT_OFS, 32'h1);
    cyc(2); chk(can_irq_n, 1'h0);
    apb(1, STAT_OFS, 32'h4); cyc(2); chk(can_irq_n, 1'h1);
    // unmapped address and read-only flag register
    apb(0, 12'h010, 0);
    chk(rd, 32'h0);
    chk(er, 1'h1);
    apb(0, FLAG_OFS, 0); chk(rd, 32'h3);
    // frozen enable: a flag change is only seen once the enable returns
    @(posedge sys_clk) sys_ce <= 1'h0;
    warn_lvl <= 1'h0;
    cyc(4);
    chk(can_irq_n, 1'h1);
    sys_ce <= 1'h1;
    cyc(3);
    chk(can_irq_n, 1'h0);
    // second reset in mid-run
    @(posedge sys_clk) sys_rst <= 1'h1;
    cyc(2);
    sys_rst <= 1'h0;
    apb(0, CTRL_OFS, 0); chk(rd, 32'h0);
    chk({can_irq_n, irq, retransmit_disable}, 3'h4);
    tally_and_finish();
  end
endmodule : cirq_ctrl_tb
